// file: sysconf_pkg.sv
`default_nettype none
package sysconf_pkg;
  localparam int unsigned NREG = 18;
  localparam logic [7:0] OFF_WAKE = 8'h30;
  localparam logic [7:0] OFF_LED = 8'h31;
  localparam logic [7:0] OFF_ADCT = 8'h32;
  localparam logic [7:0] OFF_PWM = 8'h33;
  localparam logic [7:0] OFF_PRA = 8'h34;
  localparam logic [7:0] OFF_IRQ0 = 8'h35;
  localparam logic [7:0] OFF_IRQ4A = 8'h36;
  localparam logic [7:0] OFF_IRQ4B = 8'h37;
  localparam logic [7:0] OFF_IRQ4C = 8'h38;
  localparam logic [7:0] OFF_EDGEA = 8'h39;
  localparam logic [7:0] OFF_EDGEB = 8'h3a;
  localparam logic [7:0] OFF_TXB = 8'h3e;
  localparam logic [7:0] OFF_RXB = 8'h3f;
  localparam logic [7:0] OFF_CNTL = 8'h40;
  localparam logic [7:0] OFF_CNTH = 8'h41;
  localparam logic [7:0] OFF_REF = 8'h42;
  localparam logic [7:0] OFF_IIC = 8'h50;
  localparam logic [7:0] OFF_PWR = 8'h2d;
  // byte address of register i is 4*offset
  localparam logic [7:0] REG_OFF [NREG] = '{OFF_WAKE, OFF_LED, OFF_ADCT, OFF_PWM, OFF_PRA,
    OFF_IRQ0, OFF_IRQ4A, OFF_IRQ4B, OFF_IRQ4C, OFF_EDGEA, OFF_EDGEB, OFF_TXB, OFF_RXB,
    OFF_CNTL, OFF_CNTH, OFF_REF, OFF_IIC, OFF_PWR};
  localparam logic [7:0] REG_RST [NREG] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h55, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h71};
  localparam logic [7:0] REG_MASK [NREG] = '{8'h07, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'hff,
    8'h80, 8'hff, 8'h7f, 8'hff, 8'h07, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h3f, 8'h03, 8'h71};
  localparam int unsigned IDX_PWR = 17;
  localparam int unsigned PWR_BOR_BIT = 5;
  localparam logic [5:0] CONV_GAP_BASE = 6'h03;
  localparam int unsigned BUF_SHIFT = 4;
endpackage : sysconf_pkg
`default_nettype wire

// file: system_config_register_bank.sv
`default_nettype none
module system_config_register_bank (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // power-on flag: high for the reset that comes from power-up
  input  wire logic        i_por_flag,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // settings for the peripherals
  output logic             o_lowvolt_detect_off,
  output logic             o_brownout_off,
  output logic             o_slow_crystal_off,
  output logic             o_converter_off,
  output logic      [2:0]  o_pll_wake_wait,
  output logic      [5:0]  o_conv_gap_total,
  output logic      [1:0]  o_conv_bias,
  output logic      [3:0]  o_led_port_drive,
  output logic      [7:0]  o_pwm_pin_route,
  output logic             o_serial_b_pin_pick,
  output logic      [1:0]  o_serial_a_pin_pick,
  output logic             o_twowire_pin_pick,
  output logic      [2:0]  o_irq_abc_pin_enable,
  output logic             o_irq_zero_src8_pin_enable,
  output logic      [7:0]  o_irq_zero_src_pin_enable,
  output logic      [22:7] o_irq_four_src_pin_enable,
  output logic      [7:0]  o_irq_edge_cfg,
  output logic             o_irq_four_edge_sel,
  output logic      [1:0]  o_irq_zero_edge_sel,
  output logic      [11:0] o_spi_tx_base,
  output logic      [11:0] o_spi_rx_base,
  output logic      [11:0] o_spi_count,
  output logic             o_conv_ref_internal,
  output logic             o_conv_ref_level,
  output logic      [1:0]  o_conv_int_volt_sel,
  output logic      [1:0]  o_offset_cancel_seq,
  output logic             o_twowire_analog_filter,
  output logic             o_twowire_digital_filter
);
  import sysconf_pkg::*;

  logic [7:0] regs_q [NREG];
  logic [7:0] rd_d;
  logic       hit_d;
  logic [4:0] idx_d;
  logic       acc_d;
  logic       por_seen_q;
  logic       bor_q;

  function automatic logic [4:0] decode(input logic [11:0] a);
    decode = 5'h1f;
    for (int i = 0; i < NREG; i++) begin
      if (a == {2'h0, REG_OFF[i], 2'h0}) begin
        decode = 5'(i);
      end
    end
  endfunction : decode

  always_comb begin
    idx_d = decode(i_paddr);
    hit_d = (idx_d != 5'h1f);
    rd_d = 8'h00;
    if (hit_d) begin
      rd_d = regs_q[idx_d];
      if (idx_d == 5'(IDX_PWR)) begin
        rd_d[PWR_BOR_BIT] = bor_q;
      end
    end
  end

  assign acc_d = i_psel && i_penable && !o_pready;

  // one wait state: answers on the second access cycle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= acc_d;
      o_pslverr <= acc_d && !hit_d;
      o_prdata  <= (acc_d && !i_pwrite) ? {24'h0, rd_d} : 32'h0;
    end
  end

  // power-on is caught during reset and up to the first edge after release; only then is brownout forced off
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      por_seen_q <= 1'b0;
    end else begin
      por_seen_q <= 1'b1;
    end
  end

  // brownout bit has no reset, so only power-on or a write to bit 5 of the power register sets it
  // a write in the same cycle as the power-on set wins
  always_ff @(posedge i_core_clk) begin
    if (acc_d && i_pwrite && hit_d && (idx_d == 5'(IDX_PWR))) begin
      bor_q <= i_pwdata[PWR_BOR_BIT];
    end else if (!por_seen_q && i_por_flag) begin
      bor_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RST[i];
      end
    end else begin
      if (acc_d && i_pwrite && hit_d) begin
        regs_q[idx_d] <= i_pwdata[7:0] & REG_MASK[idx_d];
      end
    end
  end

  // settings leave straight from the register flops; only o_conv_gap_total passes an adder
  always_comb begin
    o_lowvolt_detect_off = regs_q[17][6];
    o_brownout_off       = bor_q;
    o_slow_crystal_off   = regs_q[17][4];
    o_converter_off      = regs_q[17][0];
    o_pll_wake_wait      = regs_q[0][2:0];
    o_conv_gap_total     = CONV_GAP_BASE + {1'b0, regs_q[2][6:2]};
    o_conv_bias          = regs_q[2][1:0];
    o_led_port_drive          = regs_q[1][3:0];
    o_pwm_pin_route      = regs_q[3];
    o_serial_b_pin_pick  = regs_q[4][7];
    o_serial_a_pin_pick  = regs_q[4][6:5];
    o_twowire_pin_pick   = regs_q[4][4];
    o_irq_abc_pin_enable = regs_q[4][3:1];
    o_irq_zero_src8_pin_enable = regs_q[4][0];
    o_irq_zero_src_pin_enable = regs_q[5];
    o_irq_four_src_pin_enable = {regs_q[8][6:0], regs_q[7], regs_q[6][7]};
    o_irq_edge_cfg       = regs_q[9];
    o_irq_four_edge_sel  = regs_q[10][2];
    o_irq_zero_edge_sel  = regs_q[10][1:0];
    o_spi_tx_base        = {regs_q[11], 4'h0};
    o_spi_rx_base        = {regs_q[12], 4'h0};
    o_spi_count          = {regs_q[14][3:0], regs_q[13]};
    o_conv_ref_internal  = regs_q[15][5];
    o_conv_ref_level     = regs_q[15][4];
    o_conv_int_volt_sel  = regs_q[15][3:2];
    o_offset_cancel_seq  = regs_q[15][1:0];
    o_twowire_analog_filter  = regs_q[16][1];
    o_twowire_digital_filter = regs_q[16][0];
  end

  wr_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (acc_d && i_pwrite && hit_d) |=> ((regs_q[$past(idx_d)] & ~REG_MASK[$past(idx_d)]) == 8'h0))
    else $error("reserved bit stored");
  ready_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
    else $error("pready timing wrong");
  bad_addr_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (acc_d && !hit_d) |=> (o_pslverr && o_prdata == 32'h0))
    else $error("unmapped access not flagged");
  gap_sum_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_conv_gap_total == 6'(regs_q[2][6:2]) + 6'd3)
    else $error("gap count wrong");
  tx_base_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_spi_tx_base[3:0] == 4'h0 && o_spi_tx_base[11:4] == regs_q[11])
    else $error("tx base wrong");
  rx_base_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_spi_rx_base == 12'(regs_q[12]) * 12'd16)
    else $error("rx base wrong");
  por_bor_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!por_seen_q && i_por_flag && !(acc_d && i_pwrite)) |=> o_brownout_off)
    else $error("power-on did not set brownout off");
  read_back_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (acc_d && !i_pwrite && hit_d) |=> o_prdata[31:8] == 24'h0 && o_prdata[7:0] == $past(rd_d))
    else $error("read data wrong");
  count_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_spi_count[11:8] == regs_q[14][3:0])
    else $error("count high nibble wrong");
endmodule : system_config_register_bank
`default_nettype wire

// file: system_config_register_bank_tb_top.sv
`default_nettype none
module system_config_register_bank_tb_top import sysconf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, nrst = 0, por = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, seed = 32'hc018d5b1;
  logic        pready, pslverr, lvd, bor, xtal, coff, serb, twp, src8, e4, afil, dfil;
  logic [1:0]  sera, e0, ocs;
  logic [2:0]  wake, abc;
  logic [5:0]  gap;
  logic [7:0]  pwm, edg;
  logic [11:0] txb, rxb, cnt;
  logic [9:0]  q[$];
  int          mismatches = 0, tests_run = 0;
  always #5 clk = ~clk;
  system_config_register_bank dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_por_flag(por),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_lowvolt_detect_off(lvd),
    .o_brownout_off(bor), .o_slow_crystal_off(xtal), .o_converter_off(coff),
    .o_pll_wake_wait(wake), .o_conv_gap_total(gap), .o_conv_bias(), .o_led_port_drive(),
    .o_pwm_pin_route(pwm), .o_serial_b_pin_pick(serb), .o_serial_a_pin_pick(sera),
    .o_twowire_pin_pick(twp), .o_irq_abc_pin_enable(abc), .o_irq_zero_src8_pin_enable(src8),
    .o_irq_zero_src_pin_enable(), .o_irq_four_src_pin_enable(), .o_irq_edge_cfg(edg),
    .o_irq_four_edge_sel(e4), .o_irq_zero_edge_sel(e0), .o_spi_tx_base(txb),
    .o_spi_rx_base(rxb), .o_spi_count(cnt), .o_conv_ref_internal(), .o_conv_ref_level(),
    .o_conv_int_volt_sel(), .o_offset_cancel_seq(ocs), .o_twowire_analog_filter(afil),
    .o_twowire_digital_filter(dfil));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // one apb transfer; the expectation is noted before the answer can appear
  task automatic apb(input logic w, input logic [7:0] off, input logic [7:0] d,
                     input logic [7:0] e, input logic err);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= {2'h0, off, 2'h0};
    pwdata <= {rnd() & 32'hffffff00} | d;
    q.push_back({w, err, e});
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
  endtask : apb
  // answers stand one cycle, so they are taken at the negedge inside it
  always @(negedge clk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) begin
        check(1, 0);
      end else begin
        check(pslverr, q[0][8]);
        if (!q[0][9]) check(prdata, {24'h0, q[0][7:0]});
        void'(q.pop_front());
      end
    end
  end
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    por <= 0;
    @(negedge clk);
    check({lvd, bor, xtal, coff}, 4'hf);
    check(wake, 3'h7);
    check(edg, 8'h55);
    check(e4, 1'b0);
    check(e0, 2'h1);
    check(ocs, 2'h2);
    check(afil, 1'b1);
    check(dfil, 1'b0);
    check(twp, 1'b1);
    for (int i = 0; i < NREG; i++) begin
      r = rnd();
      apb(0, REG_OFF[i], 8'h00, REG_RST[i], 0);
      apb(1, REG_OFF[i], r[7:0], 8'h00, 0);
      apb(0, REG_OFF[i], 8'h00, r[7:0] & REG_MASK[i], 0);
    end
    apb(1, 8'h3b, 8'hff, 8'h00, 1);
    apb(0, 8'h3b, 8'h00, 8'h00, 1);
    r = rnd();
    apb(1, OFF_ADCT, r[7:0], 8'h00, 0);
    apb(1, OFF_TXB, r[15:8], 8'h00, 0);
    apb(1, OFF_RXB, r[23:16], 8'h00, 0);
    apb(1, OFF_CNTL, r[31:24], 8'h00, 0);
    apb(1, OFF_CNTH, r[7:0], 8'h00, 0);
    apb(1, OFF_PWM, r[15:8], 8'h00, 0);
    apb(1, OFF_PRA, r[23:16], 8'h00, 0);
    @(negedge clk);
    check(gap, 6'd3 + r[6:2]);
    check(txb, {r[15:8], 4'h0});
    check(rxb, {r[23:16], 4'h0});
    check(cnt, {r[3:0], r[31:24]});
    check(pwm, r[15:8]);
    check({serb, sera, twp, abc, src8}, r[23:16]);
    // brownout kept off, then a reset that is not a power-on one
    apb(1, OFF_PWR, 8'h20, 8'h00, 0);
    @(posedge clk);
    nrst <= 0;
    repeat (5) @(posedge clk);
    nrst <= 1;
    repeat (2) @(negedge clk);
    check(bor, 1'b1);
    check({lvd, xtal}, 2'h3);
    wrap_up();
  end
endmodule : system_config_register_bank_tb_top
`default_nettype wire
